// ==== hw/usb_sideband_pkg.sv ====
// Constants and types shared by the USB host/OTG sideband control bank
package usb_sideband_pkg;

    // =========================================================
    // Bus geometry
    // =========================================================
    localparam int          ADDR_W          = 12;       // Byte address bits decoded
    localparam int          DATA_W          = 32;       // Register bus data width
    localparam logic [1:0]  RESP_OKAY       = 2'h0;     // Normal answer
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;     // Unmapped address

    // =========================================================
    // Register map (byte addresses)
    // =========================================================
    localparam logic [ADDR_W-1:0] HOST_CTRL_OFFSET = 12'h484;
    localparam logic [ADDR_W-1:0] OTG_CTRL_OFFSET  = 12'h488;

    // =========================================================
    // Masked write layout
    // =========================================================
    localparam int          MASK_LSB        = 16;       // Write mask half starts here
    localparam int          CTRL_W          = 16;       // Stored control half

    // =========================================================
    // Reset values and writable bits
    // =========================================================
    localparam logic [15:0] HOST_CTRL_RESET    = 16'h04bc;
    localparam logic [15:0] HOST_CTRL_WRITABLE = 16'h7fff;
    localparam logic [15:0] OTG_CTRL_RESET     = 16'h0000;
    localparam logic [15:0] OTG_CTRL_WRITABLE  = 16'h0007;

    // =========================================================
    // Host control field positions
    // =========================================================
    localparam int HOST_WAKEUP_IRQ_BIT   = 14;
    localparam int HOST_ARB_HOLD_BIT     = 13;
    localparam int HOST_LEGACY_SUSP_BIT  = 12;
    localparam int HOST_MS_SHORT_BIT     = 11;
    localparam int HOST_DPLL_RESET_BIT   = 10;
    localparam int HOST_OVERCURRENT_BIT  = 9;
    localparam int HOST_AUTO_PWROFF_BIT  = 8;
    localparam int HOST_WIDE_PATH_BIT    = 7;
    localparam int HOST_NONDRIVE_BIT     = 6;
    localparam int HOST_BURST_ALIGN_BIT  = 5;
    localparam int HOST_BURST8_BIT       = 4;
    localparam int HOST_BURST4_BIT       = 3;
    localparam int HOST_BURST16_BIT      = 2;
    localparam int HOST_HUB_SHORT_BIT    = 1;
    localparam int HOST_CLK_RESTART_BIT  = 0;

    // =========================================================
    // OTG control field positions
    // =========================================================
    localparam int OTG_DEBOUNCE_BIT      = 2;
    localparam int OTG_SCALE_LSB         = 0;

    // Scale-down choices seen by the OTG core
    typedef enum logic [1:0] {
        SCALE_NONE        = 2'b00,  // Real timings everywhere
        SCALE_EXCEPT_SUSP = 2'b01,  // All but device suspend/resume
        SCALE_SUSP_ONLY   = 2'b10,  // Device suspend/resume only
        SCALE_ALL         = 2'b11   // Both groups
    } scale_mode_t;

endpackage

// ==== hw/sideband_if.sv ====
// Carrier for the stored control words between bank and output stage
`timescale 1ns/100ps
interface sideband_if;
    import usb_sideband_pkg::*;
    logic [CTRL_W-1:0] host_bits;   // Stored host control half
    logic [CTRL_W-1:0] otg_bits;    // Stored OTG control half

    modport source (output host_bits, output otg_bits);
    modport sink   (input  host_bits, input  otg_bits);
endinterface

// ==== hw/masked_reg.sv ====
// Sixteen-bit control register with per-bit write mask
`timescale 1ns/100ps
module masked_reg import usb_sideband_pkg::*; #(
    parameter logic [15:0] RESET_VALUE = 16'h0000,
    parameter logic [15:0] WRITABLE    = 16'hffff
) (
    input  wire  logic              aclk,
    input  wire  logic              aresetn,
    input  wire  logic              wr_en,
    input  wire  logic [CTRL_W-1:0] wr_mask,
    input  wire  logic [CTRL_W-1:0] wr_data,
    output logic [CTRL_W-1:0]       value
);

    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        logic [CTRL_W-1:0] value;   // Stored control bits
    } reg_state_t;

    reg_state_t state;              // Registered copy
    reg_state_t next_state;         // Next value

    // =========================================================
    // Next value
    // =========================================================
    // Only bits whose mask bit is set change; reserved bits never do
    always_comb begin
        logic [CTRL_W-1:0] m;
        m = wr_mask & WRITABLE;
        next_state = state;
        if (wr_en) begin
            next_state.value = (state.value & ~m) | (wr_data & m);
        end
        next_state.value = next_state.value & WRITABLE;
    end

    // =========================================================
    // Register
    // =========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state.value <= RESET_VALUE;
        end else begin
            state <= next_state;
        end
    end

    assign value = state.value;

endmodule

// ==== hw/sideband_drive.sv ====
// Registered drive of the named sideband signals toward the USB cores
`timescale 1ns/100ps
module sideband_drive import usb_sideband_pkg::*; (
    input  wire  logic  aclk,
    input  wire  logic  aresetn,
    sideband_if.sink    ctrl,
    output logic        phy_host_wakeup_irq_enable,
    output logic        host_arbiter_hold,
    output logic        fs_clock_legacy_suspend,
    output logic        ms_counter_short_select,
    output logic        dpll_initial_reset,
    output logic        port_overcurrent_flag,
    output logic        auto_power_off_on_overcurrent,
    output logic        phy_wide_path_select,
    output logic        phy_nondrive_sim,
    output logic        burst_align_enable,
    output logic        burst8_permit,
    output logic        burst4_permit,
    output logic        burst16_permit,
    output logic        hub_setup_short,
    output logic        fs_clock_restart,
    output logic        otg_debounce_bypass,
    output scale_mode_t otg_scale_down_mode
);

    // =========================================================
    // State: one flop per sideband line
    // =========================================================
    typedef struct packed {
        logic [CTRL_W-1:0] host;    // Host sideband lines
        logic              debnc;   // OTG debounce bypass
        scale_mode_t       scale;   // OTG scale-down selection
    } drive_state_t;

    drive_state_t state;            // Registered copy
    drive_state_t next_state;       // Next value

    // Follows the bank one cycle later; reset matches the bank reset
    always_comb begin
        next_state.host  = ctrl.host_bits;
        next_state.debnc = ctrl.otg_bits[OTG_DEBOUNCE_BIT];
        next_state.scale = scale_mode_t'(ctrl.otg_bits[OTG_SCALE_LSB +: 2]);
    end

    // =========================================================
    // Register
    // =========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state.host  <= HOST_CTRL_RESET;
            state.debnc <= OTG_CTRL_RESET[OTG_DEBOUNCE_BIT];
            state.scale <= SCALE_NONE;
        end else begin
            state <= next_state;
        end
    end

    // Static levels; the cores sample them at their own pace
    assign phy_host_wakeup_irq_enable    = state.host[HOST_WAKEUP_IRQ_BIT];
    assign host_arbiter_hold             = state.host[HOST_ARB_HOLD_BIT];
    assign fs_clock_legacy_suspend       = state.host[HOST_LEGACY_SUSP_BIT];
    assign ms_counter_short_select       = state.host[HOST_MS_SHORT_BIT];
    assign dpll_initial_reset            = state.host[HOST_DPLL_RESET_BIT];
    assign port_overcurrent_flag         = state.host[HOST_OVERCURRENT_BIT];
    assign auto_power_off_on_overcurrent = state.host[HOST_AUTO_PWROFF_BIT];
    assign phy_wide_path_select          = state.host[HOST_WIDE_PATH_BIT];
    assign phy_nondrive_sim              = state.host[HOST_NONDRIVE_BIT];
    assign burst_align_enable            = state.host[HOST_BURST_ALIGN_BIT];
    assign burst8_permit                 = state.host[HOST_BURST8_BIT];
    assign burst4_permit                 = state.host[HOST_BURST4_BIT];
    assign burst16_permit                = state.host[HOST_BURST16_BIT];
    assign hub_setup_short               = state.host[HOST_HUB_SHORT_BIT];
    assign fs_clock_restart              = state.host[HOST_CLK_RESTART_BIT];
    assign otg_debounce_bypass           = state.debnc;
    assign otg_scale_down_mode           = state.scale;

endmodule

// ==== hw/usb_host_otg_sideband_ctrl.sv ====
// Register bank driving static sideband inputs of the USB host and OTG cores
//
// How it works
// - Upper write half masks lower bit changes
// - Bit 14 gates PHY wake-up interrupt
// - Bit 13 pauses host arbiter
// - Bit 11 picks short millisecond count
// - Bit 10 drives DPLL initial reset
// - Bit 9 flags overcurrent, disabling port
// - Bit 7 selects 16-bit PHY path
// - Bit 6 makes PHY non-driving
// - Bit 5 forces aligned burst starts
// - Bits 4,3,2 permit INCR8, INCR4, INCR16
// - Bit 1 picks four-clock hub setup
// - Bit 0 drives clock restart input
// - OTG bit 2 bypasses debounce
// - OTG bits 1:0 select scale-down groups
`timescale 1ns/100ps
module usb_host_otg_sideband_ctrl import usb_sideband_pkg::*; (
    input  wire  logic              aclk,
    input  wire  logic              aresetn,
    // AXI4-Lite write address
    input  wire  logic [ADDR_W-1:0] awaddr,
    input  wire  logic [2:0]        awprot,
    input  wire  logic              awvalid,
    output logic                    awready,
    // AXI4-Lite write data
    input  wire  logic [DATA_W-1:0] wdata,
    input  wire  logic [3:0]        wstrb,
    input  wire  logic              wvalid,
    output logic                    wready,
    // AXI4-Lite write response
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire  logic              bready,
    // AXI4-Lite read address
    input  wire  logic [ADDR_W-1:0] araddr,
    input  wire  logic [2:0]        arprot,
    input  wire  logic              arvalid,
    output logic                    arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]       rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire  logic              rready,
    // Host core sideband levels
    output logic                    phy_host_wakeup_irq_enable,
    output logic                    host_arbiter_hold,
    output logic                    fs_clock_legacy_suspend,
    output logic                    ms_counter_short_select,
    output logic                    dpll_initial_reset,
    output logic                    port_overcurrent_flag,
    output logic                    auto_power_off_on_overcurrent,
    output logic                    phy_wide_path_select,
    output logic                    phy_nondrive_sim,
    output logic                    burst_align_enable,
    output logic                    burst8_permit,
    output logic                    burst4_permit,
    output logic                    burst16_permit,
    output logic                    hub_setup_short,
    output logic                    fs_clock_restart,
    // OTG core sideband levels
    output logic                    otg_debounce_bypass,
    output scale_mode_t             otg_scale_down_mode
);

    // =========================================================
    // Address decode helper
    // =========================================================
    // One-hot hit vector: bit 0 host control, bit 1 OTG control.
    // Only word index bits are compared, so byte offsets inside a
    // word land on the same register.
    function automatic logic [1:0] decode_reg(input logic [ADDR_W-1:0] a);
        logic [1:0] hit;
        hit    = 2'h0;
        hit[0] = (a[ADDR_W-1:2] == HOST_CTRL_OFFSET[ADDR_W-1:2]);
        hit[1] = (a[ADDR_W-1:2] == OTG_CTRL_OFFSET[ADDR_W-1:2]);
        return hit;
    endfunction

    // =========================================================
    // Slave state
    // =========================================================
    // Every bus output is a field of this struct, so every output
    // comes straight from a flop.
    typedef struct packed {
        logic              awready;   // Write address slot free
        logic              wready;    // Write data slot free
        logic              aw_held;   // Write address captured
        logic [ADDR_W-1:0] aw_addr;   // Captured write address
        logic              w_held;    // Write data captured
        logic [DATA_W-1:0] w_data;    // Captured write data
        logic [3:0]        w_strb;    // Captured byte enables
        logic              bvalid;    // Write answer pending
        logic [1:0]        bresp;     // Write answer code
        logic              arready;   // Read address slot free
        logic              rvalid;    // Read answer pending
        logic [DATA_W-1:0] rdata;     // Read answer data
        logic [1:0]        rresp;     // Read answer code
    } slave_state_t;

    slave_state_t state;            // Registered copy
    slave_state_t next_state;       // Next value

    // =========================================================
    // Register bank wiring
    // =========================================================
    logic              host_wr_en;    // Commit to host control
    logic              otg_wr_en;     // Commit to OTG control
    logic [CTRL_W-1:0] wr_mask;       // Effective per-bit mask
    logic [CTRL_W-1:0] wr_bits;       // Lower half of write data
    logic [CTRL_W-1:0] host_value;    // Stored host control
    logic [CTRL_W-1:0] otg_value;     // Stored OTG control

    sideband_if ctrl_bus ();          // Carries stored words to drive stage

    // =========================================================
    // Slave next-state logic
    // =========================================================
    // Address and data are captured independently, in either
    // order, then committed together in the cycle after both are
    // held. The protection bits carry no meaning here.
    always_comb begin
        logic [1:0] whit;
        logic [1:0] rhit;
        logic [1:0] lane;
        next_state = state;
        host_wr_en = 1'b0;
        otg_wr_en  = 1'b0;
        whit       = decode_reg(state.aw_addr);
        rhit       = decode_reg(araddr);

        // A mask byte only counts when its data byte also came in;
        // otherwise a half-written field could take stale bits.
        lane    = {state.w_strb[3] & state.w_strb[1],
                   state.w_strb[2] & state.w_strb[0]};
        wr_bits = state.w_data[CTRL_W-1:0];
        wr_mask = state.w_data[MASK_LSB +: CTRL_W]
                  & {{8{lane[1]}}, {8{lane[0]}}};

        // Write address capture
        if (awvalid && state.awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = awaddr;
        end

        // Write data capture
        if (wvalid && state.wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = wdata;
            next_state.w_strb = wstrb;
        end

        // Commit once both halves are held and no answer waits
        if (state.aw_held && state.w_held && !state.bvalid) begin
            host_wr_en         = whit[0];
            otg_wr_en          = whit[1];
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            if (whit != 2'h0) begin
                next_state.bresp = RESP_OKAY;
            end else begin
                // Unmapped: nothing stored, error answered
                next_state.bresp = RESP_SLVERR;
            end
        end

        // Write answer retires when the master takes it
        if (state.bvalid && bready) begin
            next_state.bvalid = 1'b0;
        end

        // Read: data sampled from the stored words at acceptance
        if (arvalid && state.arready) begin
            next_state.rvalid = 1'b1;
            if (rhit[0]) begin
                next_state.rdata = {16'h0000, host_value};
                next_state.rresp = RESP_OKAY;
            end else if (rhit[1]) begin
                next_state.rdata = {16'h0000, otg_value};
                next_state.rresp = RESP_OKAY;
            end else begin
                // Unmapped: zero data with an error code
                next_state.rdata = 32'h0000_0000;
                next_state.rresp = RESP_SLVERR;
            end
        end else if (state.rvalid && rready) begin
            next_state.rvalid = 1'b0;
        end

        // Slots reopen only when nothing is held or pending; this
        // keeps one write and one read in flight at most.
        next_state.awready = !next_state.aw_held && !next_state.bvalid;
        next_state.wready  = !next_state.w_held && !next_state.bvalid;
        next_state.arready = !next_state.rvalid;
    end

    // =========================================================
    // Slave register
    // =========================================================
    // Ready flags come up at reset so the first request needs no
    // extra cycle after release.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state.awready <= 1'b1;
            state.wready  <= 1'b1;
            state.aw_held <= 1'b0;
            state.aw_addr <= 12'h000;
            state.w_held  <= 1'b0;
            state.w_data  <= 32'h0000_0000;
            state.w_strb  <= 4'h0;
            state.bvalid  <= 1'b0;
            state.bresp   <= RESP_OKAY;
            state.arready <= 1'b1;
            state.rvalid  <= 1'b0;
            state.rdata   <= 32'h0000_0000;
            state.rresp   <= RESP_OKAY;
        end else begin
            state <= next_state;
        end
    end

    // Bus outputs are flop fields
    assign awready = state.awready;
    assign wready  = state.wready;
    assign bvalid  = state.bvalid;
    assign bresp   = state.bresp;
    assign arready = state.arready;
    assign rvalid  = state.rvalid;
    assign rdata   = state.rdata;
    assign rresp   = state.rresp;

    // =========================================================
    // Control registers
    // =========================================================
    // Host control: bit 15 reserved, so it is left out of the
    // writable set and always reads zero.
    masked_reg #(
        .RESET_VALUE (HOST_CTRL_RESET),
        .WRITABLE    (HOST_CTRL_WRITABLE)
    ) host_ctrl_reg (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (host_wr_en),
        .wr_mask (wr_mask),
        .wr_data (wr_bits),
        .value   (host_value)
    );

    // OTG control: only the debounce bypass and scale-down field
    masked_reg #(
        .RESET_VALUE (OTG_CTRL_RESET),
        .WRITABLE    (OTG_CTRL_WRITABLE)
    ) otg_ctrl_reg (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (otg_wr_en),
        .wr_mask (wr_mask),
        .wr_data (wr_bits),
        .value   (otg_value)
    );

    assign ctrl_bus.host_bits = host_value;
    assign ctrl_bus.otg_bits  = otg_value;

    // =========================================================
    // Sideband drive stage
    // =========================================================
    // The restart and legacy-suspend lines are plain levels; the
    // host core treats the restart line as asynchronous, so a
    // clean flop output avoids glitches into that input. The
    // ordering of raise/clear around suspend is left to software.
    sideband_drive drive (
        .aclk                          (aclk),
        .aresetn                       (aresetn),
        .ctrl                          (ctrl_bus),
        .phy_host_wakeup_irq_enable    (phy_host_wakeup_irq_enable),
        .host_arbiter_hold             (host_arbiter_hold),
        .fs_clock_legacy_suspend       (fs_clock_legacy_suspend),
        .ms_counter_short_select       (ms_counter_short_select),
        .dpll_initial_reset            (dpll_initial_reset),
        .port_overcurrent_flag         (port_overcurrent_flag),
        .auto_power_off_on_overcurrent (auto_power_off_on_overcurrent),
        .phy_wide_path_select          (phy_wide_path_select),
        .phy_nondrive_sim              (phy_nondrive_sim),
        .burst_align_enable            (burst_align_enable),
        .burst8_permit                 (burst8_permit),
        .burst4_permit                 (burst4_permit),
        .burst16_permit                (burst16_permit),
        .hub_setup_short               (hub_setup_short),
        .fs_clock_restart              (fs_clock_restart),
        .otg_debounce_bypass           (otg_debounce_bypass),
        .otg_scale_down_mode           (otg_scale_down_mode)
    );

endmodule

// ==== bench/sideband_checker.sv ====
// Bus answer and sideband level checks for the USB sideband bank
`timescale 1ns/100ps
module sideband_checker import usb_sideband_pkg::*; (
    input wire logic              aclk, aresetn, awready, wready, bvalid, bready,
    input wire logic              arvalid, arready, rvalid, rready, dpll_initial_reset,
    input wire logic              phy_wide_path_select, burst8_permit, burst4_permit,
    input wire logic              burst16_permit, fs_clock_restart,
    input wire logic [1:0]        bresp,
    input wire logic [DATA_W-1:0] rdata,
    input wire scale_mode_t       otg_scale_down_mode
);
    // ==========================================================
    // Checks, quiet while reset is held
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rd_answer_a: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    ar_block_a: assert property (rvalid |-> !arready) else $error("read taken early");
    rd_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0)
        else $error("mask half reads nonzero");
    reset_pins_a: assert property ($rose(aresetn) |->
        dpll_initial_reset && phy_wide_path_select && burst8_permit && burst4_permit
        && burst16_permit) else $error("sideband reset level wrong");
    reset_mode_a: assert property ($rose(aresetn) |->
        otg_scale_down_mode == SCALE_NONE && !fs_clock_restart && awready && arready)
        else $error("idle state after reset wrong");
    // Pins move only the cycle after a write answer
    hold_stable_a: assert property (!$past(bvalid) |->
        $stable({burst8_permit, burst16_permit, fs_clock_restart, otg_scale_down_mode}))
        else $error("sideband moved without write");
endmodule
bind usb_host_otg_sideband_ctrl sideband_checker chk_u (.*);

// ==== bench/usb_core_model.sv ====
// Behavioural full-speed clock gate of the host core
`timescale 1ns/100ps
module usb_core_model (
    input  wire logic aclk,
    input  wire logic fs_clock_legacy_suspend,
    input  wire logic fs_clock_restart,
    output logic      fs_clocks_on
);
    // Idle cores stop their clocks unless legacy suspend holds them; restart wins
    always @(posedge aclk)
        if (fs_clock_restart) fs_clocks_on <= 1'b1;
        else if (!fs_clock_legacy_suspend) fs_clocks_on <= 1'b0;
endmodule

// ==== bench/usb_host_otg_sideband_ctrl_bench.sv ====
// Self-checking bench for the USB host/OTG sideband control bank
`timescale 1ns/100ps
module usb_host_otg_sideband_ctrl_bench import usb_sideband_pkg::*; ;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, clocks_on, clk_exp = 0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, rd_v;
    logic [2:0] awprot = '0, arprot = '0;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] host_exp = 16'h04bc, otg_exp = 16'h0000;
    wire logic [14:0] hs;
    wire logic [2:0] os;
    int n_mismatch = 0, checks = 0;
    usb_host_otg_sideband_ctrl dut_u (.*, .phy_host_wakeup_irq_enable(hs[14]),
        .host_arbiter_hold(hs[13]), .fs_clock_legacy_suspend(hs[12]),
        .ms_counter_short_select(hs[11]), .dpll_initial_reset(hs[10]),
        .port_overcurrent_flag(hs[9]), .auto_power_off_on_overcurrent(hs[8]),
        .phy_wide_path_select(hs[7]), .phy_nondrive_sim(hs[6]), .burst_align_enable(hs[5]),
        .burst8_permit(hs[4]), .burst4_permit(hs[3]), .burst16_permit(hs[2]),
        .hub_setup_short(hs[1]), .fs_clock_restart(hs[0]), .otg_debounce_bypass(os[2]),
        .otg_scale_down_mode(os[1:0]));
    usb_core_model core_u (.aclk, .fs_clock_legacy_suspend(hs[12]),
        .fs_clock_restart(hs[0]), .fs_clocks_on(clocks_on));
    initial forever #50 aclk = ~aclk;
    // Masked update: a bit moves only where its mask bit and writable bit are set
    function automatic logic [15:0] merge(logic [15:0] old, logic [31:0] d, logic [15:0] w);
        logic [15:0] m;
        m = d[31:16] & w;
        return (old & ~m) | (d[15:0] & m);
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    // ==========================================================
    // Bus tasks: hold each channel until its own handshake edge
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        rs = bresp;
        bready <= 0;
    endtask
    task automatic rd(logic [11:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rd_v = rdata;
        rs = rresp;
        rready <= 0;
    endtask
    // Write, read back, then compare the pins against the model words
    task automatic access(logic [11:0] a, logic [31:0] d);
        logic [1:0] er;
        logic       h, o;
        logic [31:0] dm;
        h = (a == 12'h484);
        o = (a == 12'h488);
        er = (h || o) ? 2'h0 : 2'h2;
        wr(a, d);
        chk("bresp", er, rs);
        dm = d & {{8{wstrb[3] & wstrb[1]}}, {8{wstrb[2] & wstrb[0]}}, 16'hffff};
        if (h) host_exp = merge(host_exp, dm, 16'h7fff);
        if (o) otg_exp = merge(otg_exp, dm, 16'h0007);
        if (h) clk_exp = host_exp[0] | (host_exp[12] & clk_exp);
        rd(a);
        chk("rresp", er, rs);
        chk("rdata", h ? host_exp : o ? otg_exp : 16'h0, rd_v);
        chk("host pins", host_exp[14:0], hs);
        chk("otg pins", otg_exp[2:0], os);
        chk("fs clocks", clk_exp, clocks_on);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        void'($urandom(48658));
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        access(12'h484, 32'h0);
        access(12'h488, 32'h0);
        access(12'h484, 32'hffff_ffff);
        access(12'h484, 32'h0000_0000);
        access(12'h484, 32'hffff_0000);
        wstrb <= 4'h5;
        access(12'h484, 32'hffff_ffff);
        wstrb <= 4'hf;
        $display("corner writes done");
        for (int i = 0; i < 40; i++) access(12'h484 + 12'(4 * ($urandom % 3)), $urandom);
        $display("random writes done");
        for (int i = 0; i < 4; i++) access(12'h488, {16'h3, 16'(i)});
        $display("scale modes done");
        end_of_test;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        end_of_test;
    end
endmodule
